// ==== hw/esp_consts.svh ====
// Timing figures and field positions for the ECC static memory port controller.
// Assumes a single 20 MHz core clock; every count except the synchroniser depth is derived from a time in ns.
`ifndef ESP_CONSTS_SVH
`define ESP_CONSTS_SVH

// Core clock period
`define ESP_CLK_PERIOD_NS     50
// Address or select to read data valid, longest
`define ESP_READ_ACCESS_NS    45
// Shortest write strobe low time
`define ESP_WE_PULSE_NS       35
// Data setup to write end (data_setup_to_write_end)
`define ESP_DATA_SETUP_NS     25
// Write strobe low to device float (write_to_float_delay)
`define ESP_WRITE_TO_FLOAT_NS 18
// Flip-flops in each pin synchroniser
`define ESP_SYNC_STAGES       2
// Byte lane indices and lane width
`define ESP_LANE_LO           0
`define ESP_LANE_HI           1
`define ESP_BYTE_W            8
// Reset values of the pin drivers
`define ESP_DQ_RESET          16'h0000
`define ESP_ADDR_RESET        18'h0_0000

`endif

// ==== hw/esp_pkg.sv ====
// Types and shared arithmetic of the ECC static memory port controller.
// Assumes esp_consts.svh is on the include path.
`include "esp_consts.svh"

package esp_pkg;

	// Sequencer states
	typedef enum logic [2:0] {
		ESP_IDLE,
		ESP_RD_WAIT,
		ESP_WR_SETUP,
		ESP_WR_PULSE,
		ESP_WR_END
	} esp_state_t;

	// Byte lane request, bit 1 upper byte, bit 0 lower byte, active high
	typedef logic [1:0] esp_lanes_t;

	// Least time in ns to whole clock cycles, never below one
	function automatic int esp_cyc_up(input int ns);
		int c;
		c = (ns + `ESP_CLK_PERIOD_NS - 1) / `ESP_CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Larger of two counts
	function automatic int esp_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

endpackage

// ==== hw/esp_port_ctrl.sv ====
// Host side controller for an asynchronous 16-bit static memory with
// a corrected-error pin. Takes one command at a time and drives the pins.
// Assumes the memory pins are external, so inputs pass two flip-flops first.
//
// Overview of operation
// [R1] Select only with active-low low, active-high high
// [R2] Device writes while strobe, select, lane overlap
// [R3] Host asserts all write signals to begin
// [R4] First signal to go inactive ends write
// [R5] Data setup and hold reference ending edge
// [R6] Device floats data when deselected or disabled
// [R7] Strobe width covers float delay plus setup
// [R8] Device drives read data per selected lane
// [R9] Device takes write data per selected lane
// [R10] Error pin reports correction during reads only
// [R11] Host always drives selects to valid levels
// [R12] Both lanes high means deselect and standby
// [R13] Write data set up 25 ns before end
`timescale 1ns/10ps
`include "esp_consts.svh"

module esp_port_ctrl #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16,
	parameter int CNT_W  = 4
) (
	input  wire logic               core_clk,
	input  wire logic               reset,
	// User command port
	input  wire logic               cmd_valid,
	output logic                    cmd_ready,
	input  wire logic               cmd_write,
	input  wire logic [ADDR_W-1:0]  cmd_addr,
	input  wire logic [DATA_W-1:0]  cmd_wdata,
	input  wire esp_pkg::esp_lanes_t cmd_lanes,
	output logic                    rsp_valid,
	output logic [DATA_W-1:0]       rsp_rdata,
	output logic                    rsp_corrected,
	// Memory pins
	output logic [ADDR_W-1:0]       mem_addr,
	output logic                    chip_select_active_low,
	output logic                    chip_select_active_high,
	output logic                    write_strobe_n,
	output logic                    output_enable_n,
	output logic                    upper_byte_lane_select_n,
	output logic                    lower_byte_lane_select_n,
	output logic [DATA_W-1:0]       mem_dq_o,
	output logic                    mem_dq_oe,
	input  wire logic [DATA_W-1:0]  mem_dq_i,
	input  wire logic               corrected_error_i
);
	import esp_pkg::*;

	// Read wait covers access time plus the input synchroniser
	localparam int RD_CYC = esp_cyc_up(`ESP_READ_ACCESS_NS) + `ESP_SYNC_STAGES;
	// Strobe width is the larger of its own minimum and float plus setup
	localparam int WE_CYC = esp_max(esp_cyc_up(`ESP_WE_PULSE_NS),
	                                esp_cyc_up(`ESP_WRITE_TO_FLOAT_NS + `ESP_DATA_SETUP_NS));
	localparam logic [CNT_W-1:0] RD_LOAD = CNT_W'(RD_CYC);
	localparam logic [CNT_W-1:0] WE_LOAD = CNT_W'(WE_CYC);

	esp_tmr_if #(.CNT_W(CNT_W)) tmr_bus ();

	esp_timer #(.CNT_W(CNT_W)) u_timer (
		.core_clk (core_clk),
		.reset    (reset),
		.tmr      (tmr_bus.tmr)
	);

	// Sequencer and pin state
	esp_state_t          state_q, state_d;     // Sequencer state
	logic                ready_q, ready_d;     // Command accepted in idle
	logic                rsp_q, rsp_d;         // Answer pulse
	logic [DATA_W-1:0]   rdata_q, rdata_d;     // Captured read word
	logic                corr_q, corr_d;       // Captured correction flag
	logic [ADDR_W-1:0]   addr_q, addr_d;       // Address pins
	logic                sel_q, sel_d;         // Chip selected
	logic                we_q, we_d;           // Write strobe asserted
	logic                oe_q, oe_d;           // Output enable asserted
	esp_lanes_t          lanes_q, lanes_d;     // Lane selects asserted
	logic [DATA_W-1:0]   dq_q, dq_d;           // Write data pins
	logic                dq_oe_q, dq_oe_d;     // Write data driven
	logic                start_q, start_d;     // Timer start pulse
	logic [CNT_W-1:0]    load_q, load_d;       // Timer load value

	// Pin synchronisers; stage one is read by stage two only
	logic [DATA_W-1:0]   dq_s1_q, dq_s2_q;
	logic                err_s1_q, err_s2_q;

	// Keep only the lanes that were read; the others float at the pins
	function automatic logic [DATA_W-1:0] lane_mask(input esp_lanes_t l, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] m;
		m = '0;
		if (l[`ESP_LANE_LO]) begin
			m[`ESP_BYTE_W-1:0] = d[`ESP_BYTE_W-1:0];
		end
		if (l[`ESP_LANE_HI]) begin
			m[DATA_W-1:`ESP_BYTE_W] = d[DATA_W-1:`ESP_BYTE_W];
		end
		return m;
	endfunction

	// Next state of sequencer and pins
	always_comb begin
		state_d = state_q;
		ready_d = ready_q;
		rsp_d   = 1'b0;
		rdata_d = rdata_q;
		corr_d  = corr_q;
		addr_d  = addr_q;
		sel_d   = sel_q;
		we_d    = we_q;
		oe_d    = oe_q;
		lanes_d = lanes_q;
		dq_d    = dq_q;
		dq_oe_d = dq_oe_q;
		start_d = 1'b0;
		load_d  = load_q;
		unique case (state_q)
			ESP_IDLE: begin
				if (cmd_valid && ready_q) begin
					if (cmd_lanes == '0) begin
						// No lane means standby; answer without touching the pins
						rsp_d   = 1'b1; // [R12]
						rdata_d = '0;
						corr_d  = 1'b0;
					end else if (cmd_write) begin
						// Address, select, lanes and data first; strobe follows
						ready_d = 1'b0;
						addr_d  = cmd_addr;
						sel_d   = 1'b1; // [R1]
						lanes_d = cmd_lanes; // [R3]
						oe_d    = 1'b0; // [R6]
						dq_d    = cmd_wdata; // [R13]
						dq_oe_d = 1'b1;
						state_d = ESP_WR_SETUP;
					end else begin
						// Read: select, enable outputs and lanes together
						ready_d = 1'b0;
						addr_d  = cmd_addr;
						sel_d   = 1'b1; // [R1]
						lanes_d = cmd_lanes; // [R8]
						oe_d    = 1'b1;
						start_d = 1'b1;
						load_d  = RD_LOAD;
						state_d = ESP_RD_WAIT;
					end
				end
			end
			ESP_RD_WAIT: begin
				if (tmr_bus.done) begin
					// Synchronised word and error flag are settled now
					rdata_d = lane_mask(lanes_q, dq_s2_q); // [R8]
					corr_d  = err_s2_q; // [R10]
					rsp_d   = 1'b1;
					sel_d   = 1'b0;
					oe_d    = 1'b0;
					lanes_d = '0;
					ready_d = 1'b1;
					state_d = ESP_IDLE;
				end
			end
			ESP_WR_SETUP: begin
				// Last of the participating signals opens the write window
				we_d    = 1'b1; // [R3]
				start_d = 1'b1;
				load_d  = WE_LOAD; // [R7]
				state_d = ESP_WR_PULSE;
			end
			ESP_WR_PULSE: begin
				if (tmr_bus.done) begin
					// Strobe rises first and alone, so it is the ending edge
					we_d    = 1'b0; // [R4]
					state_d = ESP_WR_END;
				end
			end
			ESP_WR_END: begin
				// Data, address and selects held one cycle past the ending edge
				sel_d   = 1'b0; // [R5]
				lanes_d = '0;
				dq_oe_d = 1'b0;
				rsp_d   = 1'b1;
				ready_d = 1'b1;
				state_d = ESP_IDLE;
			end
		endcase
	end

	// Register sequencer and pin state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= ESP_IDLE;
			ready_q <= 1'b1;
			rsp_q   <= 1'b0;
			rdata_q <= `ESP_DQ_RESET;
			corr_q  <= 1'b0;
			addr_q  <= `ESP_ADDR_RESET;
			sel_q   <= 1'b0;
			we_q    <= 1'b0;
			oe_q    <= 1'b0;
			lanes_q <= '0;
			dq_q    <= `ESP_DQ_RESET;
			dq_oe_q <= 1'b0;
			start_q <= 1'b0;
			load_q  <= '0;
		end else begin
			state_q <= state_d;
			ready_q <= ready_d;
			rsp_q   <= rsp_d;
			rdata_q <= rdata_d;
			corr_q  <= corr_d;
			addr_q  <= addr_d;
			sel_q   <= sel_d;
			we_q    <= we_d;
			oe_q    <= oe_d;
			lanes_q <= lanes_d;
			dq_q    <= dq_d;
			dq_oe_q <= dq_oe_d;
			start_q <= start_d;
			load_q  <= load_d;
		end
	end

	// Two-stage synchronisers on the memory's outputs
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dq_s1_q  <= `ESP_DQ_RESET;
			dq_s2_q  <= `ESP_DQ_RESET;
			err_s1_q <= 1'b0;
			err_s2_q <= 1'b0;
		end else begin
			dq_s1_q  <= mem_dq_i;
			dq_s2_q  <= dq_s1_q;
			err_s1_q <= corrected_error_i;
			err_s2_q <= err_s1_q;
		end
	end

	// Pins come straight from flops; selects always at a full logic level
	assign cmd_ready                = ready_q;
	assign rsp_valid                = rsp_q;
	assign rsp_rdata                = rdata_q;
	assign rsp_corrected            = corr_q;
	assign mem_addr                 = addr_q;
	assign chip_select_active_low   = ~sel_q; // [R11]
	assign chip_select_active_high  = sel_q; // [R11]
	assign write_strobe_n           = ~we_q;
	assign output_enable_n          = ~oe_q;
	assign upper_byte_lane_select_n = ~lanes_q[`ESP_LANE_HI];
	assign lower_byte_lane_select_n = ~lanes_q[`ESP_LANE_LO];
	assign mem_dq_o                 = dq_q;
	assign mem_dq_oe                = dq_oe_q;
	// Timer request comes from flops, so the timer sees no combinational path
	assign tmr_bus.start            = start_q;
	assign tmr_bus.load             = load_q;
endmodule

// ==== hw/esp_timer.sv ====
// Down counter that times the write strobe width and the read wait for the port sequencer.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/10ps

module esp_timer #(
	parameter int CNT_W = 4
) (
	input  wire logic core_clk,
	input  wire logic reset,
	esp_tmr_if.tmr    tmr
);
	import esp_pkg::*;

	logic [CNT_W-1:0] cnt_q, cnt_d;    // Cycles still to wait
	logic             done_q, done_d;  // Expiry pulse

	// Load on start, count down, pulse once on reaching zero
	always_comb begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (tmr.start) begin
			cnt_d = tmr.load;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
			// Last counted cycle raises done
			done_d = (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
		end
	end

	// Register only
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign tmr.done = done_q;
endmodule

// ==== hw/esp_tmr_if.sv ====
// Carrier between the port sequencer and its cycle timer.
// Assumes both ends share the core clock.
`timescale 1ns/10ps

interface esp_tmr_if #(
	parameter int CNT_W = 4
);
	logic             start;  // One-cycle pulse, loads the count
	logic [CNT_W-1:0] load;   // Cycles to wait
	logic             done;   // One-cycle pulse when the wait has run out

	modport seq (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface

// ==== verification/esp_mem_model.sv ====
// Behavioural model of the 16-bit static memory with corrected-error pin.
// Assumes the bench resolves the data bus; floating lines show a toggling pattern.
`timescale 1ns/10ps
module esp_mem_model (
	input  wire logic        core_clk,
	input  wire logic [17:0] mem_addr,
	input  wire logic        chip_select_active_low,
	input  wire logic        chip_select_active_high,
	input  wire logic        write_strobe_n,
	input  wire logic        output_enable_n,
	input  wire logic        upper_byte_lane_select_n,
	input  wire logic        lower_byte_lane_select_n,
	input  wire logic [15:0] mem_dq_o,
	input  wire logic        mem_dq_oe,
	output wire logic [15:0] mem_dq_i,
	output wire logic        corrected_error_i
);
	logic [15:0] mem [16]; // Small array, upper address bits alias
	logic [15:0] flt = 16'h5555; // Float pattern, never a stale value
	wire [3:0] ix = mem_addr[3:0];
	// Both lanes high deselects whatever the chip selects do
	wire sel = !chip_select_active_low && chip_select_active_high &&
		!(upper_byte_lane_select_n && lower_byte_lane_select_n);
	wire wr = sel && !write_strobe_n;
	wire rd = sel && write_strobe_n && !output_enable_n;
	wire [15:0] din = mem_dq_oe ? mem_dq_o : ~mem_dq_o; // Undriven bus is garbage
	// Float pattern flips each cycle
	always @(posedge core_clk) flt <= ~flt;
	// Write follows the overlap window, lanes gate bytes
	always @* begin
		if (wr && !lower_byte_lane_select_n) mem[ix][7:0] = din[7:0];
		if (wr && !upper_byte_lane_select_n) mem[ix][15:8] = din[15:8];
	end
	// Unselected lanes and disabled outputs float
	assign #40 mem_dq_i = {rd && !upper_byte_lane_select_n ? mem[ix][15:8] : flt[15:8],
		rd && !lower_byte_lane_select_n ? mem[ix][7:0] : flt[7:0]};
	// Address bit 4 marks a word stored with a single-bit fault
	assign #40 corrected_error_i = rd ? mem_addr[4] : flt[0];
endmodule

// ==== verification/esp_port_ctrl_chk.sv ====
// Pin and command timing checker for the static memory port controller.
// Assumes it is bound to esp_port_ctrl and sees only its ports.
`timescale 1ns/10ps
module esp_port_ctrl_chk #(
	parameter int ADDR_W = 18,
	parameter int DATA_W = 16
) (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic              cmd_valid,
	input wire logic              cmd_ready,
	input wire logic              cmd_write,
	input wire esp_pkg::esp_lanes_t cmd_lanes,
	input wire logic              rsp_valid,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              chip_select_active_low,
	input wire logic              chip_select_active_high,
	input wire logic              write_strobe_n,
	input wire logic              output_enable_n,
	input wire logic              upper_byte_lane_select_n,
	input wire logic              lower_byte_lane_select_n,
	input wire logic [DATA_W-1:0] mem_dq_o,
	input wire logic              mem_dq_oe
);
	import esp_pkg::*;
	// Device counts as selected with both selects and a lane active
	wire act = !chip_select_active_low && chip_select_active_high &&
		!(upper_byte_lane_select_n && lower_byte_lane_select_n);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Strobe low three cycles: one loaded count plus the timer's start and done registers
	sequence s_wr_pulse;
		!write_strobe_n [*3] ##1 write_strobe_n;
	endsequence
	// Command taken with at least one lane
	sequence s_take(w);
		cmd_valid && cmd_ready && cmd_write == w && cmd_lanes != 2'h0;
	endsequence
	chk_select_pair: assert property (chip_select_active_low == !chip_select_active_high)
		else $error("selects not complementary");
	chk_write_qual: assert property (!write_strobe_n |-> act && mem_dq_oe && output_enable_n)
		else $error("write strobe without full qualification");
	chk_we_width: assert property ($fell(write_strobe_n) |-> s_wr_pulse)
		else $error("write strobe width wrong");
	chk_we_ends: assert property ($rose(write_strobe_n) |-> act && mem_dq_oe && $stable(mem_dq_o))
		else $error("write not ended by strobe alone");
	chk_data_held: assert property (!write_strobe_n |-> $stable(mem_dq_o) && $stable(mem_addr))
		else $error("data or address moved in write");
	chk_read_float: assert property (!output_enable_n |-> !mem_dq_oe && write_strobe_n)
		else $error("host drives bus in read");
	chk_write_answer: assert property (s_take(1'b1) |-> ##6 rsp_valid)
		else $error("write answer late");
	chk_read_answer: assert property (s_take(1'b0) |-> ##[5:7] rsp_valid)
		else $error("read answer late");
	chk_nolane_idle: assert property (
		cmd_valid && cmd_ready && cmd_lanes == 2'h0 |-> ##1 rsp_valid && !act)
		else $error("no-lane command touched pins");
endmodule
bind esp_port_ctrl esp_port_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_esp_port_ctrl_chk (
	.core_clk, .reset, .cmd_valid, .cmd_ready, .cmd_write, .cmd_lanes, .rsp_valid, .mem_addr,
	.chip_select_active_low, .chip_select_active_high, .write_strobe_n, .output_enable_n,
	.upper_byte_lane_select_n, .lower_byte_lane_select_n, .mem_dq_o, .mem_dq_oe);

// ==== verification/esp_port_ctrl_tb.sv ====
// Self-checking bench for the static memory port controller.
// Assumes the memory model and bound checker; inputs change at falling edges.
`timescale 1ns/10ps
module esp_port_ctrl_tb;
	import esp_pkg::*;
	logic        core_clk = 0, reset = 1, cmd_valid = 0, cmd_write = 0;
	logic [17:0] cmd_addr = 18'h0_0000;
	logic [15:0] cmd_wdata = 16'h0000;
	esp_lanes_t  cmd_lanes = 2'h0;
	wire         cmd_ready, rsp_valid, rsp_corrected, mem_dq_oe, corrected_error_i;
	wire         chip_select_active_low, chip_select_active_high, write_strobe_n;
	wire         output_enable_n, upper_byte_lane_select_n, lower_byte_lane_select_n;
	wire [15:0]  rsp_rdata, mem_dq_o, mem_dq_i;
	wire [17:0]  mem_addr;
	int          err_total = 0, checks = 0;
	// 20 MHz core clock
	always #25 core_clk = ~core_clk;
	esp_port_ctrl i_esp_port_ctrl (.core_clk, .reset, .cmd_valid, .cmd_ready, .cmd_write,
		.cmd_addr, .cmd_wdata, .cmd_lanes, .rsp_valid, .rsp_rdata, .rsp_corrected, .mem_addr,
		.chip_select_active_low, .chip_select_active_high, .write_strobe_n, .output_enable_n,
		.upper_byte_lane_select_n, .lower_byte_lane_select_n, .mem_dq_o, .mem_dq_oe,
		.mem_dq_i, .corrected_error_i);
	esp_mem_model i_esp_mem_model (.core_clk, .mem_addr, .chip_select_active_low,
		.chip_select_active_high, .write_strobe_n, .output_enable_n, .upper_byte_lane_select_n,
		.lower_byte_lane_select_n, .mem_dq_o, .mem_dq_oe, .mem_dq_i, .corrected_error_i);
	// One comparison, counted
	task check(input string nm, input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Verdict and end of run
	task summarize;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One command, held until taken, then wait for its answer
	task acc(input logic w, input logic [17:0] a, input logic [15:0] d, input esp_lanes_t l);
		int n;
		@(negedge core_clk);
		{cmd_valid, cmd_write, cmd_addr, cmd_wdata, cmd_lanes} = {1'b1, w, a, d, l};
		for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) @(negedge core_clk);
		@(negedge core_clk);
		cmd_valid = 0;
		for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(negedge core_clk);
		check("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
	endtask
	// Idle pin levels: ready, selects off, strobes high, bus released
	task t_idle;
		check("idle", {7'h00, cmd_ready, rsp_valid, chip_select_active_low, chip_select_active_high,
			write_strobe_n, output_enable_n, upper_byte_lane_select_n, lower_byte_lane_select_n,
			mem_dq_oe}, 16'h015E);
	endtask
	// Full word write and read back, clean word
	task t_full;
		acc(1, 18'h0_0003, 16'hA5C3, 2'h3);
		acc(0, 18'h0_0003, 16'h0000, 2'h3);
		check("full", rsp_rdata, 16'hA5C3);
		check("clean", {15'h0000, rsp_corrected}, 16'h0000);
	endtask
	// Upper lane only write leaves lower byte, single lane reads zero the rest
	task t_lanes;
		acc(1, 18'h0_0003, 16'h1234, 2'h2);
		acc(0, 18'h0_0003, 16'h0000, 2'h3);
		check("upper_wr", rsp_rdata, 16'h12C3);
		acc(0, 18'h0_0003, 16'h0000, 2'h1);
		check("lower_rd", rsp_rdata, 16'h00C3);
		acc(0, 18'h0_0003, 16'h0000, 2'h2);
		check("upper_rd", rsp_rdata, 16'h1200);
	endtask
	// Word flagged as corrected by the memory
	task t_err;
		acc(1, 18'h0_0015, 16'h0F0F, 2'h3);
		acc(0, 18'h0_0015, 16'h0000, 2'h3);
		check("err_data", rsp_rdata, 16'h0F0F);
		check("err_flag", {15'h0000, rsp_corrected}, 16'h0001);
	endtask
	// No lanes: standby, answer zero
	task t_nolane;
		acc(0, 18'h0_0015, 16'h0000, 2'h0);
		check("nolane_data", rsp_rdata, 16'h0000);
		check("nolane_flag", {15'h0000, rsp_corrected}, 16'h0000);
		// Answer pulse stands one cycle; idle levels are judged after it
		@(negedge core_clk);
		t_idle();
	endtask
	// Reset in mid-run, then traffic again
	task t_rst;
		reset = 1;
		repeat (2) @(negedge core_clk);
		t_idle();
		reset = 0;
		t_full();
	endtask
	// Watchdog, about five times the expected run
	initial begin
		#20000;
		err_total++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (4) @(negedge core_clk);
		reset = 0;
		t_idle();
		t_full();
		t_lanes();
		t_err();
		t_nolane();
		t_rst();
		summarize();
	end
endmodule
